// ---- pkg/dsp_pkg.sv ----
package dsp_pkg;
	localparam int FRAME_BITS = 24;
	localparam int CMD_BITS = 8;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] ADDR_RESET = 5'h00;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_RSVD = 2'h1;
	localparam logic [1:0] OP_RSVD2 = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	// Command byte layout: addr[7:3], opcode[2:1], reserved[0]
	localparam int ADDR_MSB = 7;
	localparam int ADDR_LSB = 3;
	localparam int OP_MSB = 2;
	localparam int OP_LSB = 1;
	localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
	localparam logic [4:0] BIT_CNT_LAST = 5'h17;
	localparam logic [4:0] BIT_CNT_CMD = 5'h07;
	localparam logic [4:0] BIT_CNT_ERR_OUT = 5'h07;

	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] data;
	} dsp_word_t;
endpackage

// ---- src/dsp_spi_slave.sv ----
// Behaviour
// - Slave only; serial clock always comes from the master.
// - Mode 0,0 or 1,1 picked from clock level at select fall.
// - Input bit sampled on each rising serial clock edge.
// - Output bit changes on each falling serial clock edge.
// - Select active starts driving output and zeroes bit counter.
// - Traffic handled in 24-bit units framed by select.
// - Error drives error bit low; held until select inactive.
// - Select inactive resets bit counter, output, NV pending flag and address pointer.
// - Clock and input ignored while select is inactive.
// - Power-on reset clears state machine and address pointer.
// - Five-bit location field selects one of 32 locations.
// - Frame is command byte with reserved bit, then data word.
// - High-voltage pin marks command HV; reads only normal.
// - HV input shares the latch pin; used for nonvolatile writes.
// - Output high for seven command bits, then error flag.
// - Non-multiple-of-24 frames: partial tail never executed, complete volatile units still written.
// - After error all commands ignored, output low until release.
// - Nonvolatile write starts only after full frame and release.
`timescale 1ns/1ns
`default_nettype none
module dsp_spi_slave #(
	parameter logic [4:0] NV_ADDR_MIN = 5'h10
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic hv_program_pin,
	output logic sdo_o,
	output logic sdo_oe_n,
	output logic mode11_r,
	output logic [4:0] addr_ptr_r,
	output logic wr_strobe,
	output logic nv_start,
	output dsp_pkg::dsp_word_t wr_word_r,
	output logic hv_cmd_r,
	input wire logic [15:0] rd_data,
	input wire logic nv_busy,
	output logic command_error_flag
);
	////////////////////////////////////////////////////////////////
	// Two-flop synchronisers; only the second stage is read
	logic [1:0] sck_s, cs_s, sdi_s, hv_s;
	logic sck_q, cs_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sck_s <= 2'h0;
			cs_s <= 2'h3;
			sdi_s <= 2'h0;
			hv_s <= 2'h0;
			sck_q <= 1'h0;
			cs_q <= 1'h1;
		end else begin
			sck_s <= {sck_s[0], sck};
			cs_s <= {cs_s[0], cs_n};
			sdi_s <= {sdi_s[0], sdi};
			hv_s <= {hv_s[0], hv_program_pin};
			sck_q <= sck_s[1];
			cs_q <= cs_s[1];
		end
	end
	// Master clock is only observed, never produced
	wire logic sel = !cs_s[1];
	wire logic cs_fall = cs_q && !cs_s[1];
	wire logic cs_rise = !cs_q && cs_s[1];
	// Edges only count while selected
	wire logic rise = sel && !cs_fall && !sck_q && sck_s[1];
	wire logic fall = sel && !cs_fall && sck_q && !sck_s[1];

	function automatic logic cmd_valid(input logic [1:0] op,
		input logic hv);
		// Reserved opcodes and HV reads are invalid
		case (op)
			dsp_pkg::OP_WRITE: cmd_valid = 1'b1;
			dsp_pkg::OP_READ: cmd_valid = !hv;
			default: cmd_valid = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		DSP_IDLE = 3'b001,
		DSP_RUN = 3'b010,
		DSP_ERR = 3'b100
	} dsp_state_t;
	dsp_state_t st_r, st_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [23:0] sh_r, sh_nxt;
	logic [15:0] out_r, out_nxt;
	logic sdo_r, sdo_nxt, mode_nxt, hv_nxt, nvp_r, nvp_nxt;
	logic [4:0] addr_nxt;
	logic [1:0] op_r, op_nxt;
	dsp_pkg::dsp_word_t word_nxt;
	logic wr_nxt, nvs_nxt;
	logic wr_q, nvs_q;
	logic [23:0] sh_in;
	logic refuse_now;
	logic [4:0] addr7;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		out_nxt = out_r;
		sdo_nxt = sdo_r;
		mode_nxt = mode11_r;
		hv_nxt = hv_cmd_r;
		nvp_nxt = nvp_r;
		addr_nxt = addr_ptr_r;
		op_nxt = op_r;
		word_nxt = wr_word_r;
		wr_nxt = 1'b0;
		nvs_nxt = 1'b0;
		sh_in = {sh_r[22:0], sdi_s[1]};
		// Flag rides the reserved bit, so the first seven bits decide it
		addr7 = sh_r[dsp_pkg::ADDR_MSB - 1:dsp_pkg::ADDR_LSB - 1];
		// Any command after an NV write in one frame is refused as well
		refuse_now = !cmd_valid(
			sh_r[dsp_pkg::OP_MSB - 1:dsp_pkg::OP_LSB - 1], hv_s[1]) ||
			nvp_r || (nv_busy && addr7 >= NV_ADDR_MIN);
		case (st_r)
			DSP_IDLE: begin
				if (cs_fall) begin
					st_nxt = DSP_RUN;
					mode_nxt = sck_s[1];
					cnt_nxt = dsp_pkg::BIT_CNT_ZERO;
					sdo_nxt = 1'b1;
				end
			end
			DSP_RUN: begin
				if (rise) begin
					sh_nxt = sh_in;
					cnt_nxt = (cnt_r == dsp_pkg::BIT_CNT_LAST) ?
						dsp_pkg::BIT_CNT_ZERO : 5'(cnt_r + 5'h01);
					if (cnt_r == dsp_pkg::BIT_CNT_CMD) begin
						// Command byte complete
						addr_nxt = sh_in[dsp_pkg::ADDR_MSB:dsp_pkg::ADDR_LSB];
						op_nxt = sh_in[dsp_pkg::OP_MSB:dsp_pkg::OP_LSB];
						hv_nxt = hv_s[1];
						out_nxt = rd_data;
					end
					if (cnt_r == dsp_pkg::BIT_CNT_LAST &&
						op_r == dsp_pkg::OP_WRITE) begin
						// Executes only on a full 24th bit
						word_nxt.addr = addr_ptr_r;
						word_nxt.data = sh_in[15:0];
						if (addr_ptr_r >= NV_ADDR_MIN) begin
							nvp_nxt = 1'b1;
						end else begin
							wr_nxt = 1'b1;
						end
					end
				end
				if (fall) begin
					if (cnt_r == dsp_pkg::BIT_CNT_ERR_OUT) begin
						st_nxt = refuse_now ? DSP_ERR : DSP_RUN;
						sdo_nxt = !refuse_now; // high when valid
					end else if (cnt_r > dsp_pkg::BIT_CNT_CMD &&
						op_r == dsp_pkg::OP_READ) begin
						sdo_nxt = out_r[15];
						out_nxt = {out_r[14:0], 1'b0};
					end else begin
						sdo_nxt = 1'b1;
					end
				end
				if (cs_rise) begin
					// NV program only after whole frame and release
					nvs_nxt = nvp_r && cnt_r == dsp_pkg::BIT_CNT_ZERO;
					st_nxt = DSP_IDLE;
				end
			end
			DSP_ERR: begin
				if (fall) begin
					sdo_nxt = 1'b0;
				end
				if (cs_rise) begin
					st_nxt = DSP_IDLE;
				end
			end
			default: st_nxt = DSP_IDLE;
		endcase
		if (cs_rise) begin
			// Pointer, bit counter, NV pending and output reset on release
			addr_nxt = dsp_pkg::ADDR_RESET;
			cnt_nxt = dsp_pkg::BIT_CNT_ZERO;
			nvp_nxt = 1'b0;
			sdo_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_r <= DSP_IDLE;
			cnt_r <= dsp_pkg::BIT_CNT_ZERO;
			sh_r <= 24'h000000;
			out_r <= 16'h0000;
			sdo_r <= 1'b1;
			mode11_r <= 1'b0;
			hv_cmd_r <= 1'b0;
			nvp_r <= 1'b0;
			addr_ptr_r <= dsp_pkg::ADDR_RESET;
			op_r <= dsp_pkg::OP_WRITE;
			wr_word_r <= '0;
			wr_q <= 1'b0;
			nvs_q <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			out_r <= out_nxt;
			sdo_r <= sdo_nxt;
			mode11_r <= mode_nxt;
			hv_cmd_r <= hv_nxt;
			nvp_r <= nvp_nxt;
			addr_ptr_r <= addr_nxt;
			op_r <= op_nxt;
			wr_word_r <= word_nxt;
			wr_q <= wr_nxt;
			nvs_q <= nvs_nxt;
		end
	end

	assign wr_strobe = wr_q;
	assign nv_start = nvs_q;
	assign sdo_o = sdo_r;
	// Driven only while selected, released otherwise
	assign sdo_oe_n = !sel;
	assign command_error_flag = (st_r != DSP_ERR);

	////////////////////////////////////////////////////////////////
	property p_err_low;
		@(posedge clk_sys) disable iff (!rst_n)
		(st_r == DSP_ERR && fall) |=> !sdo_o;
	endproperty
	a_err_low: assert property (p_err_low) else $error("err sdo high");

	property p_release;
		@(posedge clk_sys) disable iff (!rst_n)
		cs_rise |=> (addr_ptr_r == 5'h00 && cnt_r == 5'h00);
	endproperty
	a_release: assert property (p_release) else $error("no reset");

	property p_oe;
		@(posedge clk_sys) disable iff (!rst_n)
		(st_r == DSP_IDLE && !cs_fall) |-> sdo_oe_n;
	endproperty
	a_oe: assert property (p_oe) else $error("sdo driven idle");

	property p_mode;
		@(posedge clk_sys) disable iff (!rst_n)
		(st_r == DSP_IDLE && cs_fall) |=> mode11_r == $past(sck_s[1]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");

	property p_cnt0;
		@(posedge clk_sys) disable iff (!rst_n)
		(st_r == DSP_IDLE && cs_fall) |=> cnt_r == 5'h00 && !sdo_oe_n;
	endproperty
	a_cnt0: assert property (p_cnt0) else $error("start wrong");

	property p_ignore;
		@(posedge clk_sys) disable iff (!rst_n)
		(cs_s[1] && cs_q) |=> $stable(cnt_r) && $stable(sh_r);
	endproperty
	a_ignore: assert property (p_ignore) else $error("idle activity");

	property p_nvstart;
		@(posedge clk_sys) disable iff (!rst_n)
		nv_start |-> $past(cs_rise) && $past(nvp_r);
	endproperty
	a_nvstart: assert property (p_nvstart) else $error("bad nv");

	property p_wr;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_strobe |-> $past(cnt_r, 2) == 5'h17 && st_r != DSP_ERR;
	endproperty
	a_wr: assert property (p_wr) else $error("partial write");

	property p_hvread;
		@(posedge clk_sys) disable iff (!rst_n)
		(fall && st_r == DSP_RUN && cnt_r == 5'h07 && hv_s[1] &&
			sh_r[1:0] == 2'h3) |=> st_r == DSP_ERR;
	endproperty
	a_hvread: assert property (p_hvread) else $error("hv read ok");
endmodule
`default_nettype wire

// ---- dv/dsp_spi_master.sv ----
`timescale 1ns/1ns
`default_nettype none
module dsp_spi_master (
	input wire logic sdo,
	output logic sck,
	output logic cs_n,
	output logic sdi
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// Link clock free of clk_sys phase; still outside frames
	task automatic xfer(input logic md, input logic [47:0] tx, input int n,
		output logic [47:0] rx);
		rx = '0;
		sck = md;
		#200;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++) begin
			sck = 1'b0;
			sdi = tx[n - 1 - i];
			#62; // 8 MHz, under both limits
			sck = 1'b1;
			rx = {rx[46:0], sdo};
			#63;
		end
		sck = md;
		#100;
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask
endmodule
`default_nettype wire

// ---- dv/tb_dsp_spi_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_dsp_spi_slave;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic hv_program_pin = 1'b0;
	logic nv_busy = 1'b0;
	logic [15:0] rd_data = 16'h3c5a;
	wire sck, cs_n, sdi, sdo_w;
	logic sdo_o, sdo_oe_n, mode11_r, wr_strobe, nv_start, hv_cmd_r, cef;
	logic [4:0] addr_ptr_r;
	dsp_pkg::dsp_word_t wr_word_r;
	logic [47:0] rx;
	logic mseen, ok;
	int fails = 0, checks = 0, wcnt = 0, ncnt = 0, w0, n0, ecnt = 0, e0;
	always #2 clk_sys = ~clk_sys;
	// Released line shows the inverse so a stale bit never passes
	assign sdo_w = sdo_oe_n ? ~sdo_o : sdo_o;
	dsp_spi_slave dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sck(sck),
		.cs_n(cs_n), .sdi(sdi), .hv_program_pin(hv_program_pin),
		.sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .mode11_r(mode11_r),
		.addr_ptr_r(addr_ptr_r), .wr_strobe(wr_strobe), .nv_start(nv_start),
		.wr_word_r(wr_word_r), .hv_cmd_r(hv_cmd_r), .rd_data(rd_data),
		.nv_busy(nv_busy), .command_error_flag(cef));
	dsp_spi_master m_u (.sdo(sdo_w), .sck(sck), .cs_n(cs_n), .sdi(sdi));
	always @(posedge clk_sys) begin
		wcnt <= wcnt + int'(wr_strobe);
		ncnt <= ncnt + int'(nv_start);
		ecnt <= ecnt + int'(!cef);
		if (!cs_n)
			mseen <= mode11_r;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic md, input logic [47:0] tx, input int n);
		w0 = wcnt;
		n0 = ncnt;
		e0 = ecnt;
		m_u.xfer(md, tx, n, rx);
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic results();
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		results();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(sdo_oe_n, 1'b1);
		chk(addr_ptr_r, 5'h00);
		// Every opcode, alternating the two modes
		for (int i = 0; i < 4; i++) begin
			frame(i[0], {24'h0, 5'h04, i[1:0], 1'b0, 16'h1234}, 24);
			ok = (i == 0) || (i == 3);
			chk(mseen, i[0]);
			chk(ecnt != e0, !ok);
			chk(rx[23:16], ok ? 8'hff : 8'hfe);
			if (!ok)
				chk(rx[15:0], 16'h0000);
			if (i == 3)
				chk(rx[15:0], 16'h3c5a);
			chk(wcnt - w0, i == 0);
			if (i == 0)
				chk(wr_word_r, {5'h04, 16'h1234});
		end
		chk(addr_ptr_r, 5'h00);
		chk(sdo_oe_n, 1'b1);
		chk(hv_cmd_r, 1'b0);
		frame(1'b0, {5'h04, 3'h0, 16'hbeef} >> 4, 20);
		chk(wcnt - w0, 0);
		frame(1'b1, {5'h01, 3'h0, 16'h1111, 5'h02, 3'h0, 16'h2222}, 48);
		chk(wcnt - w0, 2);
		chk(wr_word_r, {5'h02, 16'h2222});
		@(posedge clk_sys) hv_program_pin <= 1'b1;
		frame(1'b0, {5'h05, 3'h6, 16'h0000}, 24);
		chk(rx[23:16], 8'hfe);
		chk(ecnt != e0, 1'b1);
		frame(1'b0, {5'h12, 3'h0, 16'h5a5a}, 24);
		chk(hv_cmd_r, 1'b1);
		chk(wcnt - w0, 0);
		chk(ncnt - n0, 1);
		chk(wr_word_r, {5'h12, 16'h5a5a});
		@(posedge clk_sys) nv_busy <= 1'b1;
		frame(1'b0, {5'h13, 3'h0, 16'h0f0f}, 24);
		chk(rx[23:16], 8'hfe);
		chk(ncnt - n0, 0);
		@(posedge clk_sys) nv_busy <= 1'b0;
		frame(1'b1, {5'h13, 3'h0, 16'h0f0f}, 24);
		chk(ncnt - n0, 1);
		chk(wr_word_r, {5'h13, 16'h0f0f});
		frame(1'b0, {5'h12, 3'h0, 16'h0001, 5'h01, 3'h0, 16'h0002}, 48);
		chk(rx[23:16], 8'hfe);
		chk(ncnt - n0, 0);
		chk(wcnt - w0, 0);
		@(posedge clk_sys) hv_program_pin <= 1'b0;
		results();
	end
endmodule
`default_nettype wire
